// ===== logic/microcore_load_mul_decode.sv
`timescale 1ns/1ps
module microcore_load_mul_decode
    import microcore_pkg::*;
#(
    parameter int OUT_W = 8
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [ADR_W-1:0]         adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    input  wire logic [MEM_AW-1:0]        base_addr_i,
    input  wire logic [$clog2(OUT_W)-1:0] shortcut_map_a_i,
    input  wire logic [$clog2(OUT_W)-1:0] shortcut_map_b_i,
    output logic      [OUT_W-1:0]         outputs_o,
    output logic      [1:0]               count_sel_o,
    output logic                          count_load_o,
    output logic                          count_reset_o
);
    function automatic op_t classify(input logic [WORD_W-1:0] w);
        if (w[15:14] == TAG_LDCD) begin
            return OP_LDCD;
        end else if (w[15:14] == TAG_LOAD && w[1:0] == TAG_LOAD_END) begin
            return OP_LOAD;
        end else if (w[15:12] == TAG_JUMP_A && w[1:0] == TAG_JUMP_END) begin
            return OP_JUMP_A;
        end else if (w[15:12] == TAG_JUMP_B && w[1:0] == TAG_JUMP_END) begin
            return OP_JUMP_B;
        end else if (w[15:11] == TAG_IMM && w[1:0] == TAG_IMM_HIGH) begin
            return OP_IMM_HIGH;
        end else if (w[15:11] == TAG_IMM && w[1:0] == TAG_IMM_LOW) begin
            return OP_IMM_LOW;
        end else if (w[15:6] == TAG_MUL) begin
            return OP_MUL;
        end
        return OP_NONE;
    endfunction : classify

    // base add wraps inside the 64-word scratch memory
    function automatic logic [MEM_AW-1:0] eff_addr(
        input logic              indexed,
        input logic [MEM_AW-1:0] addr,
        input logic [MEM_AW-1:0] base
    );
        logic [MEM_AW-1:0] sum;
        sum = addr + base;
        return indexed ? sum : addr;
    endfunction : eff_addr

    function automatic logic [WORD_W-1:0] merge16(
        input logic [WORD_W-1:0] old,
        input logic [31:0]       data,
        input logic [3:0]        sel
    );
        logic [WORD_W-1:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = data[7:0];
        end
        if (sel[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    logic [WORD_W-1:0]   scratch_mem [2**MEM_AW];
    logic [WORD_W-1:0]   core_reg_set [8];
    logic [WORD_W-1:0]   count_limit_reg [4];
    logic [WORD_W-1:0]   immediate_word_reg;
    logic [WORD_W-1:0]   jump_target_a;
    logic [WORD_W-1:0]   jump_target_b;
    logic [WORD_W-1:0]   product_high;
    logic [WORD_W-1:0]   product_low;
    logic                product_overflow_flag;
    logic                precision_loss_flag;
    logic                operation_done_flag;

    logic                bus_req;
    logic                wr_fire;
    logic                issue_stall;
    logic                issue;
    logic [WORD_W-1:0]   instr;
    op_t                 op;
    logic                indexed_addr_mode;
    logic                counter_clear;
    logic [1:0]          shortcut_action_a;
    logic [1:0]          shortcut_action_b;
    logic [1:0]          limit_sel;
    logic [MEM_AW-1:0]   mem_addr;
    logic [MEM_AW-1:0]   mem_eff;
    logic [WORD_W-1:0]   mem_word;
    logic [2:0]          first_operand_reg;
    logic [2:0]          second_operand_reg;
    logic [2:0]          load_dest;
    logic                clear_upper_byte;
    logic                clear_lower_byte;
    logic [7:0]          byte_operand;
    logic [9:0]          jump_target_operand;
    logic [OUT_W-1:0]    after_a;
    logic [OUT_W-1:0]    after_b;
    logic                mul_busy;
    logic                mul_done;
    logic [2*WORD_W-1:0] product_pair;
    logic [31:0]         rd_mux;

    assign bus_req = cyc_i && stb_i;
    assign wr_fire = bus_req && we_i && ack_o;
    // a new instruction waits for the running multiply
    assign issue_stall = we_i && adr_i == OFS_INSTR && mul_busy;
    assign issue = wr_fire && adr_i == OFS_INSTR && sel_i[1:0] == 2'b11;
    assign instr = dat_i[WORD_W-1:0];
    assign op = issue ? classify(instr) : OP_NONE;

    assign indexed_addr_mode = (op == OP_LOAD) ? instr[2] : instr[13];
    assign counter_clear = instr[12];
    assign shortcut_action_a = instr[11:10];
    assign shortcut_action_b = instr[9:8];
    assign limit_sel = instr[7:6];
    assign mem_addr = (op == OP_LOAD) ? instr[11:6] : instr[5:0];
    assign first_operand_reg = instr[2:0];
    assign second_operand_reg = instr[5:3];
    assign load_dest = instr[5:3];
    assign clear_upper_byte = instr[10];
    assign clear_lower_byte = instr[10];
    assign byte_operand = instr[9:2];
    assign jump_target_operand = instr[11:2];
    assign mem_eff = eff_addr(indexed_addr_mode, mem_addr, base_addr_i);
    assign mem_word = scratch_mem[mem_eff];

    shortcut_apply #(
        .OUT_W    (OUT_W)
    ) u_shortcut_a (
        .state_i  (outputs_o),
        .map_i    (shortcut_map_a_i),
        .action_i (shortcut_action_a),
        .state_o  (after_a)
    );

    shortcut_apply #(
        .OUT_W    (OUT_W)
    ) u_shortcut_b (
        .state_i  (after_a),
        .map_i    (shortcut_map_b_i),
        .action_i (shortcut_action_b),
        .state_o  (after_b)
    );

    seq_multiplier u_mul (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (op == OP_MUL),
        .a_i       (core_reg_set[first_operand_reg]),
        .b_i       (core_reg_set[second_operand_reg]),
        .busy_o    (mul_busy),
        .done_o    (mul_done),
        .product_o (product_pair)
    );

    // registered ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req && !ack_o && !issue_stall;
            if (bus_req && !ack_o) begin
                dat_o <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (adr_i[8]) begin
            rd_mux = {16'h0000, scratch_mem[adr_i[7:2]]};
        end else if (adr_i[8:5] == OFS_CORE_BASE) begin
            rd_mux = {16'h0000, core_reg_set[adr_i[4:2]]};
        end else if (adr_i[8:4] == {1'b0, OFS_LIMIT_BASE}) begin
            rd_mux = {16'h0000, count_limit_reg[adr_i[3:2]]};
        end else begin
            case (adr_i)
                OFS_STATUS:    rd_mux = {28'h0000000, mul_busy, operation_done_flag,
                                         precision_loss_flag, product_overflow_flag};
                OFS_IMM:       rd_mux = {16'h0000, immediate_word_reg};
                OFS_JUMP_A:    rd_mux = {16'h0000, jump_target_a};
                OFS_JUMP_B:    rd_mux = {16'h0000, jump_target_b};
                OFS_PROD_HIGH: rd_mux = {16'h0000, product_high};
                OFS_PROD_LOW:  rd_mux = {16'h0000, product_low};
                OFS_OUTPUTS:   rd_mux = 32'(outputs_o);
                default:       rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // scratch memory has no reset; software fills it before use
    always_ff @(posedge clk_i) begin
        if (wr_fire && adr_i[8]) begin
            scratch_mem[adr_i[7:2]] <= merge16(scratch_mem[adr_i[7:2]], dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                core_reg_set[i] <= WORD_RESET;
            end
        end else if (op == OP_LOAD) begin
            core_reg_set[load_dest] <= mem_word;
        end else if (wr_fire && adr_i[8:5] == OFS_CORE_BASE) begin
            core_reg_set[adr_i[4:2]] <= merge16(core_reg_set[adr_i[4:2]], dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                count_limit_reg[i] <= WORD_RESET;
            end
        end else if (op == OP_LDCD) begin
            count_limit_reg[limit_sel] <= mem_word;
        end
    end

    // counter itself lives outside; it sees a load pulse and a clear pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_sel_o   <= 2'h0;
            count_load_o  <= 1'b0;
            count_reset_o <= 1'b0;
        end else begin
            count_load_o  <= op == OP_LDCD;
            count_reset_o <= op == OP_LDCD && counter_clear;
            if (op == OP_LDCD) begin
                count_sel_o <= limit_sel;
            end
        end
    end

    // first shortcut applied, then second on its result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            outputs_o <= '0;
        end else if (op == OP_LDCD) begin
            outputs_o <= after_b;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            immediate_word_reg <= WORD_RESET;
        end else if (op == OP_IMM_HIGH) begin
            immediate_word_reg[15:8] <= clear_upper_byte ? 8'h00 : byte_operand;
        end else if (op == OP_IMM_LOW) begin
            immediate_word_reg[7:0] <= clear_lower_byte ? 8'h00 : byte_operand;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jump_target_a <= WORD_RESET;
            jump_target_b <= WORD_RESET;
        end else if (op == OP_JUMP_A) begin
            jump_target_a <= {6'h00, jump_target_operand};
        end else if (op == OP_JUMP_B) begin
            jump_target_b <= {6'h00, jump_target_operand};
        end
    end

    // plain multiply never shifts, so precision loss stays clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            product_high          <= WORD_RESET;
            product_low           <= WORD_RESET;
            product_overflow_flag <= 1'b0;
            precision_loss_flag   <= 1'b0;
            operation_done_flag   <= 1'b0;
        end else if (op == OP_MUL) begin
            operation_done_flag <= 1'b0;
        end else if (mul_done) begin
            product_high          <= product_pair[31:16];
            product_low           <= product_pair[15:0];
            product_overflow_flag <= product_pair[31:16] != 16'h0000;
            precision_loss_flag   <= 1'b0;
            operation_done_flag   <= 1'b1;
        end
    end
endmodule : microcore_load_mul_decode

// ===== include/microcore_pkg.sv
// Contract
// - limit load from memory, then apply shortcuts
// - reset bit clears counter, else keeps count
// - index bit: 0 direct, 1 indexed address
// - indexed address adds stored base value
// - shortcut: keep, off, on, invert
// - shortcuts act on mapped output positions
// - selector 00..11 picks limit one..four
// - limit load word layout, tag 01
// - upper immediate byte takes operand
// - clear bit zeroes upper immediate byte
// - upper immediate word layout, ends 11
// - lower immediate byte load or clear
// - lower immediate word layout, ends 10
// - jump target a load, tag 1000
// - jump target b load, tag 1001
// - memory word into chosen core register
// - memory load word layout, tag 10
// - multiply, high register holds upper half
// - multiply takes 17 core cycles
// - multiply updates three condition flags
// - multiply word layout, tag 0010110110
// - low register holds lower product half
package microcore_pkg;
    localparam int ADR_W = 9;
    localparam int WORD_W = 16;
    localparam int MEM_AW = 6;
    localparam int MUL_CYCLES = 17;

    localparam logic [ADR_W-1:0] OFS_INSTR = 9'h000;
    localparam logic [ADR_W-1:0] OFS_STATUS = 9'h004;
    localparam logic [ADR_W-1:0] OFS_IMM = 9'h008;
    localparam logic [ADR_W-1:0] OFS_JUMP_A = 9'h00c;
    localparam logic [ADR_W-1:0] OFS_JUMP_B = 9'h010;
    localparam logic [ADR_W-1:0] OFS_PROD_HIGH = 9'h014;
    localparam logic [ADR_W-1:0] OFS_PROD_LOW = 9'h018;
    localparam logic [ADR_W-1:0] OFS_OUTPUTS = 9'h01c;
    localparam logic [3:0] OFS_LIMIT_BASE = 4'h2;
    localparam logic [3:0] OFS_CORE_BASE = 4'h2;

    localparam logic [1:0] TAG_LDCD = 2'h1;
    localparam logic [1:0] TAG_LOAD = 2'h2;
    localparam logic [1:0] TAG_LOAD_END = 2'h2;
    localparam logic [3:0] TAG_JUMP_A = 4'h8;
    localparam logic [3:0] TAG_JUMP_B = 4'h9;
    localparam logic [1:0] TAG_JUMP_END = 2'h0;
    localparam logic [4:0] TAG_IMM = 5'h07;
    localparam logic [1:0] TAG_IMM_HIGH = 2'h3;
    localparam logic [1:0] TAG_IMM_LOW = 2'h2;
    localparam logic [9:0] TAG_MUL = 10'h0b6;

    localparam logic [1:0] ACT_KEEP = 2'h0;
    localparam logic [1:0] ACT_OFF = 2'h1;
    localparam logic [1:0] ACT_ON = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_LDCD     = 3'b001,
        OP_IMM_HIGH = 3'b010,
        OP_IMM_LOW  = 3'b011,
        OP_JUMP_A   = 3'b100,
        OP_JUMP_B   = 3'b101,
        OP_LOAD     = 3'b110,
        OP_MUL      = 3'b111
    } op_t;
endpackage : microcore_pkg

// ===== logic/shortcut_apply.sv
`timescale 1ns/1ps
module shortcut_apply
    import microcore_pkg::*;
#(
    parameter int OUT_W = 8
) (
    input  wire logic [OUT_W-1:0]         state_i,
    input  wire logic [$clog2(OUT_W)-1:0] map_i,
    input  wire logic [1:0]               action_i,
    output logic      [OUT_W-1:0]         state_o
);
    always_comb begin
        state_o = state_i;
        case (action_i)
            ACT_OFF:    state_o[map_i] = 1'b0;
            ACT_ON:     state_o[map_i] = 1'b1;
            ACT_TOGGLE: state_o[map_i] = ~state_i[map_i];
            default:    state_o = state_i;
        endcase
    end
endmodule : shortcut_apply

// ===== logic/seq_multiplier.sv
`timescale 1ns/1ps
module seq_multiplier
    import microcore_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              start_i,
    input  wire logic [WORD_W-1:0] a_i,
    input  wire logic [WORD_W-1:0] b_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic [2*WORD_W-1:0]    product_o
);
    // one shift-add step per cycle plus a final write-back cycle
    logic [2*WORD_W-1:0] acc;
    logic [2*WORD_W-1:0] mcand;
    logic [WORD_W-1:0]   mplier;
    logic [4:0]          step;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            step      <= 5'h00;
            acc       <= 32'h0000_0000;
            mcand     <= 32'h0000_0000;
            mplier    <= 16'h0000;
            product_o <= 32'h0000_0000;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                step   <= 5'h00;
                acc    <= 32'h0000_0000;
                mcand  <= {16'h0000, a_i};
                mplier <= b_i;
            end else if (busy_o) begin
                if (step == 5'(MUL_CYCLES - 1)) begin
                    busy_o <= 1'b0;
                end else begin
                    // result leaves with the last add so it lands as busy falls
                    if (step == 5'(MUL_CYCLES - 2)) begin
                        product_o <= mplier[0] ? acc + mcand : acc;
                        done_o    <= 1'b1;
                    end
                    if (mplier[0]) begin
                        acc <= acc + mcand;
                    end
                    mcand  <= {mcand[2*WORD_W-2:0], 1'b0};
                    mplier <= {1'b0, mplier[WORD_W-1:1]};
                    step   <= step + 5'h01;
                end
            end
        end
    end
endmodule : seq_multiplier

// ===== verification/microcore_load_mul_decode_checker.sv
`timescale 1ns/1ps
module microcore_load_mul_decode_checker
    import microcore_pkg::*;
#(
    parameter int OUT_W = 8
) (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     cyc_i,
    input wire logic                     stb_i,
    input wire logic                     we_i,
    input wire logic [ADR_W-1:0]         adr_i,
    input wire logic [3:0]               sel_i,
    input wire logic [31:0]              dat_i,
    input wire logic                     ack_o,
    input wire logic [$clog2(OUT_W)-1:0] shortcut_map_a_i,
    input wire logic [$clog2(OUT_W)-1:0] shortcut_map_b_i,
    input wire logic [OUT_W-1:0]         outputs_o,
    input wire logic [1:0]               count_sel_o,
    input wire logic                     count_load_o,
    input wire logic                     count_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [$clog2(OUT_W)-1:0] map_a_q;
    logic [$clog2(OUT_W)-1:0] map_b_q;
    logic                     ldcd_go;
    assign ldcd_go = ack_o && we_i && adr_i == OFS_INSTR && sel_i[1:0] == 2'b11 && dat_i[15:14] == TAG_LDCD;

    // maps as seen at the execute edge
    always_ff @(posedge clk_i) begin
        map_a_q <= shortcut_map_a_i;
        map_b_q <= shortcut_map_b_i;
    end

    property p_load_cause;
        count_load_o |-> $past(ldcd_go);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("limit load without instruction");
    property p_load_follow;
        ldcd_go |=> count_load_o;
    endproperty
    a_load_follow: assert property (p_load_follow) else $error("limit load pulse missing");
    property p_sel;
        count_load_o |-> count_sel_o == $past(dat_i[7:6]);
    endproperty
    a_sel: assert property (p_sel) else $error("wrong limit selected");
    property p_rst;
        count_load_o |-> count_reset_o == $past(dat_i[12]);
    endproperty
    a_rst: assert property (p_rst) else $error("counter clear mismatch");
    property p_rst_only;
        count_reset_o |-> count_load_o;
    endproperty
    a_rst_only: assert property (p_rst_only) else $error("clear without load");
    property p_out_hold;
        !count_load_o |-> $stable(outputs_o);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("outputs moved without shortcut");
    property p_on_a;
        count_load_o && $past(dat_i[11:10]) == ACT_ON && map_a_q != map_b_q |-> outputs_o[map_a_q];
    endproperty
    a_on_a: assert property (p_on_a) else $error("first shortcut on failed");
    property p_off_b;
        count_load_o && $past(dat_i[9:8]) == ACT_OFF |-> !outputs_o[map_b_q];
    endproperty
    a_off_b: assert property (p_off_b) else $error("second shortcut off failed");
    property p_answer;
        $rose(cyc_i && stb_i) |-> ##[1:20] ack_o;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
endmodule : microcore_load_mul_decode_checker

bind microcore_load_mul_decode microcore_load_mul_decode_checker #(.OUT_W(OUT_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .shortcut_map_a_i(shortcut_map_a_i),
    .shortcut_map_b_i(shortcut_map_b_i), .outputs_o(outputs_o), .count_sel_o(count_sel_o),
    .count_load_o(count_load_o), .count_reset_o(count_reset_o));

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench
    import microcore_pkg::*;
;
    localparam int OUT_W = 8;
    localparam int LIMIT = 3000;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc_i = 1'b0;
    logic             stb_i = 1'b0;
    logic             we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = '0;
    logic [3:0]       sel_i = '0;
    logic [31:0]      dat_i = '0;
    logic [MEM_AW-1:0] base_addr_i = 6'h3e;
    logic [2:0]       map_a = 3'h2;
    logic [2:0]       map_b = 3'h5;
    logic [31:0]      dat_o;
    logic             ack_o;
    logic [OUT_W-1:0] outputs_o;
    logic [OUT_W-1:0] exp_out = '0;
    logic [1:0]       count_sel_o;
    logic [1:0]       last_sel;
    logic             count_load_o;
    logic             count_reset_o;
    logic             last_rst;
    int               bad_count = 0;
    int               n_tests = 0;
    int               cyc_n = 0;
    int               loads = 0;

    microcore_load_mul_decode #(.OUT_W(OUT_W)) u_microcore_load_mul_decode (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .base_addr_i(base_addr_i),
        .shortcut_map_a_i(map_a), .shortcut_map_b_i(map_b), .outputs_o(outputs_o),
        .count_sel_o(count_sel_o), .count_load_o(count_load_o), .count_reset_o(count_reset_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (count_load_o === 1'b1) begin
            loads <= loads + 1;
            last_sel <= count_sel_o;
            last_rst <= count_reset_o;
        end
    end

    always @(posedge clk_i) begin
        if (cyc_n == LIMIT) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // entered just after a rising edge; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        chk({31'h0, ack_o}, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'h3, q);
    endtask : wr

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk(q & m, e);
    endtask : rd_chk

    function automatic logic [OUT_W-1:0] act(input logic [OUT_W-1:0] s, input int k, input logic [1:0] c);
        act = s;
        case (c)
            ACT_OFF: act[k] = 1'b0;
            ACT_ON: act[k] = 1'b1;
            ACT_TOGGLE: act[k] = ~s[k];
            default: ;
        endcase
    endfunction : act

    task automatic t_regs();
        wr(9'h0f0, 32'h5555);
        rd_chk(9'h0f0, '1, 32'h0);
        wr(OFS_OUTPUTS, 32'hff);
        rd_chk(OFS_OUTPUTS, '1, 32'h0);
        wr(9'h1fc, 32'hc3a5);
        rd_chk(9'h1fc, '1, 32'hc3a5);
        $display("test regs done");
    endtask : t_regs

    task automatic t_imm();
        wr(OFS_INSTR, {16'h0, TAG_IMM, 1'b0, 8'ha5, TAG_IMM_HIGH});
        rd_chk(OFS_IMM, 32'hff00, 32'ha500);
        wr(OFS_INSTR, {16'h0, TAG_IMM, 1'b0, 8'h3c, TAG_IMM_LOW});
        rd_chk(OFS_IMM, '1, 32'ha53c);
        wr(OFS_INSTR, {16'h0, TAG_IMM, 1'b1, 8'h77, TAG_IMM_HIGH});
        rd_chk(OFS_IMM, '1, 32'h003c);
        wr(OFS_INSTR, {16'h0, TAG_IMM, 1'b1, 8'h77, TAG_IMM_LOW});
        rd_chk(OFS_IMM, '1, 32'h0);
        $display("test immediate done");
    endtask : t_imm

    task automatic t_jump();
        logic [31:0] q;
        wr(OFS_INSTR, {16'h0, TAG_JUMP_A, 10'h3ff, TAG_JUMP_END});
        rd_chk(OFS_JUMP_A, '1, 32'h03ff);
        wr(OFS_INSTR, {16'h0, TAG_JUMP_B, 10'h155, TAG_JUMP_END});
        rd_chk(OFS_JUMP_B, '1, 32'h0155);
        // partial byte enables must not execute
        wb(1'b1, OFS_INSTR, {16'h0, TAG_JUMP_A, 10'h001, TAG_JUMP_END}, 4'h1, q);
        rd_chk(OFS_JUMP_A, '1, 32'h03ff);
        $display("test jump done");
    endtask : t_jump

    task automatic t_load();
        wr(9'h114, 32'h1234);
        wr(9'h120, 32'h5678);
        wr(9'h128, 32'h9999);
        wr(OFS_INSTR, {16'h0, TAG_LOAD, 2'b00, 6'd5, 3'd3, 1'b0, TAG_LOAD_END});
        rd_chk(9'h04c, '1, 32'h1234);
        // 10 + 62 wraps to word 8
        wr(OFS_INSTR, {16'h0, TAG_LOAD, 2'b00, 6'd10, 3'd6, 1'b1, TAG_LOAD_END});
        rd_chk(9'h058, '1, 32'h5678);
        $display("test load done");
    endtask : t_load

    task automatic t_ldcd();
        logic [5:0] ad;
        logic [1:0] aa;
        logic [1:0] ab;
        int         l0;
        for (int i = 0; i < 4; i++) begin
            wr(9'h150 + 9'(4 * i), 32'h1000 + 32'(i * 32'h0111));
            ad = (i == 3) ? 6'd25 : 6'(20 + i);
            aa = 2'(i);
            ab = 2'(3 - i);
            l0 = loads;
            wr(OFS_INSTR, {16'h0, TAG_LDCD, 1'(i == 3), i[0], aa, ab, 2'(i), ad});
            exp_out = act(act(exp_out, int'(map_a), aa), int'(map_b), ab);
            @(posedge clk_i);
            chk(32'(loads - l0), 32'h1);
            chk({30'h0, last_sel}, 32'(i));
            chk({31'h0, last_rst}, {31'h0, i[0]});
            chk({24'h0, outputs_o}, {24'h0, exp_out});
            rd_chk(9'h020 + 9'(4 * i), '1, 32'h1000 + 32'(i * 32'h0111));
        end
        rd_chk(OFS_OUTPUTS, '1, {24'h0, exp_out});
        $display("test limit done");
    endtask : t_ldcd

    task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] p;
        int          t0;
        p = {16'h0, a} * {16'h0, b};
        wr(9'h044, {16'h0, a});
        wr(9'h048, {16'h0, b});
        wr(OFS_INSTR, {16'h0, TAG_MUL, 3'd2, 3'd1});
        t0 = cyc_n;
        rd_chk(OFS_STATUS, 32'hc, 32'h8);
        // the next instruction waits out the multiply
        wr(OFS_INSTR, {16'h0, TAG_JUMP_B, 10'h03f, TAG_JUMP_END});
        // 16 remaining busy edges, then ack, its sampling edge and the release edge
        chk(32'(cyc_n - t0), 32'h13);
        rd_chk(OFS_JUMP_B, '1, 32'h003f);
        rd_chk(OFS_PROD_HIGH, '1, {16'h0, p[31:16]});
        rd_chk(OFS_PROD_LOW, '1, {16'h0, p[15:0]});
        rd_chk(OFS_STATUS, 32'hf, {28'h0, 2'b01, 1'b0, 1'(p[31:16] != 16'h0)});
        $display("test multiply done");
    endtask : t_mul

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_imm();
        t_jump();
        t_load();
        t_ldcd();
        t_mul(16'hffff, 16'h0003);
        t_mul(16'h00ff, 16'h0100);
        end_of_test();
    end
endmodule : testbench
